// File: include/pfc_pkg.sv
// Package: flag positions, masks, register map and carrier structs for the flags block
package pfc_pkg;

  // ==========================================================================
  // Flag bit positions
  localparam int unsigned FL_CARRY   = 0;
  localparam int unsigned FL_PARITY  = 2;
  localparam int unsigned FL_NIBBLE  = 4;
  localparam int unsigned FL_ZERO    = 6;
  localparam int unsigned FL_SIGN    = 7;
  localparam int unsigned FL_TRAP    = 8;
  localparam int unsigned FL_INT     = 9;
  localparam int unsigned FL_DIR     = 10;
  localparam int unsigned FL_OVFL    = 11;
  localparam int unsigned FL_IO_PRIV_LEVEL_LO = 12;
  localparam int unsigned FL_NEST    = 14;
  localparam int unsigned FL_RESUME  = 16;
  localparam int unsigned FL_V86     = 17;
  localparam int unsigned FL_ALIGN   = 18;
  localparam int unsigned FL_VIF     = 19;
  localparam int unsigned FL_VIP     = 20;
  localparam int unsigned FL_PROBE   = 21;

  // ==========================================================================
  // Masks and fixed values of the 64-bit flags image
  localparam int unsigned FL_W         = 22;
  localparam logic [21:0] FL_WR_MASK   = 22'h3f7fd5;
  localparam logic [21:0] FL_STAT_MASK = 22'h0008d5;
  localparam logic [21:0] FL_ONE_MASK  = 22'h000002;
  localparam logic [21:0] FL_RESET     = 22'h000002;

  // ==========================================================================
  // Register map (byte offsets) and control fields
  localparam logic [3:0] REG_FLAGS_LO = 4'h0;
  localparam logic [3:0] REG_FLAGS_HI = 4'h4;
  localparam logic [3:0] REG_CTRL     = 4'h8;
  localparam logic [3:0] REG_STAT     = 4'hc;
  localparam int unsigned CT_LONG64   = 0;
  localparam int unsigned CT_LEGACY   = 1;
  localparam int unsigned CT_CPL_LO   = 2;
  localparam int unsigned CT_V86EXT   = 4;
  localparam int unsigned CT_PVI      = 5;
  localparam logic [5:0] CTRL_RESET   = 6'h00;
  localparam logic [3:0] CR_TASK_PRI  = 4'h8;
  localparam logic [1:0] PRIV_LEAST   = 2'h3;

  // ==========================================================================
  // Pipeline event carrier
  typedef struct packed {
    logic        retire;      // Instruction completed successfully
    logic        flag_wr;     // Instruction writes flags
    logic [21:0] flag_wdata;  // Flag value written
    logic [21:0] flag_wmask;  // Which flags it writes
    logic        alu_upd;     // Arithmetic result updates status
    logic [21:0] alu_flags;   // Status values at their positions
    logic        io_instr;    // I/O-space instruction
    logic        cr_access;   // Control register access
    logic        reg_extend_prefix_bit;       // Register-extend prefix bit
    logic [2:0]  operand_select_byte_reg;   // Operand select reg field
    logic        return_from_interrupt;        // Return from interrupt retires
    logic        return_from_interrupt_rf;     // Reloaded image has resume set
    logic        gate_xfer;   // Jump/call/soft int through task gate
    logic        gate_nest;   // Call/int/exception through task gate
    logic        exc_take;    // Exception or interrupt being taken
    logic        str_break;   // String instruction interrupted
    logic        bp_hit;      // Instruction breakpoint match
    logic        ext_int;     // Maskable external interrupt request
    logic        nmi;         // Non-maskable interrupt request
    logic        soft_int;    // Software interrupt instruction
    logic        if_op;       // Set/clear interrupt instruction
    logic        if_val;      // Value it writes
  } pfc_pipe_s;

  typedef struct packed {
    logic        debug_trap;  // Step or breakpoint trap
    logic        prot_fault;  // Protection fault
    logic        bad_opcode;  // Bad opcode fault
    logic        task_back;   // Return to enclosing task
    logic        int_accept;  // Maskable interrupt accepted
    logic        nmi_accept;  // Non-maskable / soft interrupt taken
    logic        cr_valid;    // Control register decode valid
    logic [3:0]  cr_num;      // Decoded control register number
  } pfc_evt_s;

endpackage : pfc_pkg

// File: rtl/pfc_flags.sv
// Flags register, system flag behaviour and control-register decode
//
// Contract
// - Long mode: extend prefix bit plus reg field selects control registers 8-15.
// - Access to an unprovided control register raises bad opcode fault.
// - Task priority register is control register 8, reachable only in 64-bit mode.
// - Flags bits 63:22, 15, 5, 3 read zero; bit 1 reads one.
// - Legacy view equals low 32 bits of the 64-bit flags.
// - Arithmetic results update the six status bits, readable at any level.
// - Trap flag set raises debug trap after each completed instruction.
// - Stepping starts after the instruction that sets the trap flag.
// - Trap flag clears on debug trap and on any exception or interrupt; here a software interrupt leaves it unchanged.
// - Interrupt flag set accepts maskable interrupts; clear ignores them.
// - NMI, software interrupts and exceptions ignore the interrupt flag.
// - Interrupt flag change allowed by privilege, I/O level and virtual enables.
// - I/O instructions need current level <= I/O level, else protection fault.
// - Virtual enables make I/O level govern virtual interrupts and flag changes.
// - Task-gate call, interrupt or exception sets nested task.
// - Legacy return from interrupt with nested set switches back to enclosing task.
// - Resume flag clears after each instruction, one later after the two cases.
// - Resume flag set suppresses repeated instruction-breakpoint debug trap.
// - Exception or string interruption stacks flags image with resume set.
// - Breakpoint debug trap stacks flags image with resume clear.
// - Protected virtual interrupts change only set/clear interrupt to use VIRTUAL_INT_FLAG.
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/100ps
`default_nettype none

module pfc_flags
  import pfc_pkg::*;
#(
  parameter logic [6:0] CR_IMPL_HI = 7'h00  // Which of control regs 9-15 exist
)(
  input  wire logic      sys_clk,    // Core clock, 200 MHz
  input  wire logic      rst_b,      // Asynchronous reset, active low
  input  wire pfc_pipe_s pipe,       // Pipeline events, same clock
  input  wire logic [3:0] bus_addr,  // Register byte address
  input  wire logic [31:0] bus_wdata, // Write data
  input  wire logic      bus_wr,     // Write strobe
  input  wire logic      bus_rd,     // Read strobe
  output logic [31:0]    bus_rdata,  // Read data, cycle after strobe
  output logic [63:0]    flags_register,   // Full flags view
  output logic [31:0]    legacy_flags_low, // Low 32-bit view
  output logic [63:0]    stack_image,      // Flags image pushed on entry
  output pfc_evt_s       evt               // Registered event pulses
);

  // ==========================================================================
  // Elaboration check
  initial
  begin
    if (FL_W != 22)
      $error("pfc_flags: flag width must be 22");
  end

  // ==========================================================================
  // State
  logic [21:0] flags;
  logic [5:0]  ctrl;
  logic        rf_hold;
  logic [21:0] next_flags;
  logic [1:0]  current_priv_level;
  logic [1:0]  io_priv_level;
  logic        virt_en;
  logic        io_ok;
  logic        step_trap;
  logic        bp_trap;
  logic        if_fault;
  logic        int_take;
  logic        cr_ok;
  logic [3:0]  cr_sel;
  logic [63:0] next_view;
  logic [63:0] cur_view;

  assign current_priv_level     = ctrl[CT_CPL_LO +: 2];
  assign io_priv_level    = flags[FL_IO_PRIV_LEVEL_LO +: 2];
  assign virt_en = ctrl[CT_V86EXT] | ctrl[CT_PVI];

  // Fixed bits forced on every view, whatever is stored
  function automatic logic [63:0] view(input logic [21:0] f);
    view = {42'h0, (f & FL_WR_MASK) | FL_ONE_MASK};
  endfunction

  // Whole views, so halves can be sliced from a named net
  assign next_view = view(next_flags);
  assign cur_view  = view(flags);

  // ==========================================================================
  // Decode of traps, faults and control register numbers
  always_comb
  begin
    io_ok     = (current_priv_level <= io_priv_level);
    step_trap = pipe.retire & flags[FL_TRAP];
    bp_trap   = pipe.bp_hit & ~flags[FL_RESUME];
    int_take  = pipe.ext_int & flags[FL_INT];
    // Interrupt flag change: direct if privileged enough, else virtual or fault
    if_fault  = pipe.if_op & ~io_ok &
                ~(virt_en & (io_priv_level != PRIV_LEAST));
    cr_sel    = {pipe.reg_extend_prefix_bit & ctrl[CT_LONG64], pipe.operand_select_byte_reg};
    case (cr_sel)
      4'h0, 4'h2, 4'h3, 4'h4: cr_ok = 1'b1;
      CR_TASK_PRI:            cr_ok = ctrl[CT_LONG64];
      4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf:
                              cr_ok = CR_IMPL_HI[cr_sel[2:0] - 3'h1];
      default:                cr_ok = 1'b0;
    endcase
  end

  // ==========================================================================
  // Next flags: bus write first, then pipeline, hardware events last so they win
  always_comb
  begin
    next_flags = flags;
    if (bus_wr && bus_addr == REG_FLAGS_LO)
      next_flags = (bus_wdata[21:0] & FL_WR_MASK) | FL_ONE_MASK;
    if (pipe.flag_wr)
      next_flags = (next_flags & ~(pipe.flag_wmask & FL_WR_MASK)) |
                   (pipe.flag_wdata & pipe.flag_wmask & FL_WR_MASK);
    if (pipe.alu_upd)
      next_flags = (next_flags & ~FL_STAT_MASK) |
                   (pipe.alu_flags & FL_STAT_MASK);
    if (pipe.if_op && !if_fault)
    begin
      if (io_ok)
        next_flags[FL_INT] = pipe.if_val;
      else
        next_flags[FL_VIF] = pipe.if_val;
    end
    // Resume flag: held over one more instruction after the two special cases
    if (pipe.retire)
    begin
      if (pipe.return_from_interrupt && pipe.return_from_interrupt_rf)
        next_flags[FL_RESUME] = 1'b1;
      else if (!pipe.gate_xfer)
        next_flags[FL_RESUME] = 1'b0;
    end
    if (pipe.gate_nest)
      next_flags[FL_NEST] = 1'b1;
    // Stepping, breakpoints, exceptions, accepted interrupts and NMI shut single-step off; software interrupts do not
    if (step_trap || bp_trap || pipe.exc_take || int_take || pipe.nmi)
      next_flags[FL_TRAP] = 1'b0;
  end

  // ==========================================================================
  // Flags register
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      flags <= FL_RESET;
    else
      flags <= next_flags;
  end

  // Resume hold marker, tracks the deferred clear
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      rf_hold <= 1'b0;
    else if (pipe.retire)
      rf_hold <= (pipe.return_from_interrupt & pipe.return_from_interrupt_rf) | pipe.gate_xfer;
  end

  // Control register, written by software
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      ctrl <= CTRL_RESET;
    else if (bus_wr && bus_addr == REG_CTRL)
      ctrl <= bus_wdata[5:0];
  end

  // ==========================================================================
  // Registered views; legacy view is the low half
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      flags_register   <= 64'h2;
      legacy_flags_low <= 32'h2;
    end
    else
    begin
      flags_register   <= next_view;
      legacy_flags_low <= next_view[31:0];
    end
  end

  // Stacked image on entry; breakpoint entry leaves resume clear
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      stack_image <= 64'h2;
    else if (bp_trap)
      stack_image <= view(flags) & ~(64'h1 << FL_RESUME);
    else if (pipe.exc_take || pipe.str_break)
      stack_image <= view(flags) | (64'h1 << FL_RESUME);
  end

  // ==========================================================================
  // Event pulses, one cycle each
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      evt <= '0;
    else
    begin
      evt.debug_trap <= step_trap | bp_trap;
      evt.prot_fault <= (pipe.io_instr & ~io_ok) | if_fault |
                        (pipe.if_op & pipe.if_val & ~io_ok &
                         flags[FL_VIP]);
      evt.bad_opcode <= pipe.cr_access & ~cr_ok;
      evt.task_back  <= pipe.return_from_interrupt & ctrl[CT_LEGACY] &
                        flags[FL_NEST];
      evt.int_accept <= int_take;
      evt.nmi_accept <= pipe.nmi | pipe.soft_int;
      evt.cr_valid   <= pipe.cr_access & cr_ok;
      evt.cr_num     <= cr_sel;
    end
  end

  // ==========================================================================
  // Register read port, data one cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      bus_rdata <= 32'h0;
    else if (bus_rd)
    begin
      case (bus_addr)
        REG_FLAGS_LO: bus_rdata <= cur_view[31:0];
        REG_FLAGS_HI: bus_rdata <= cur_view[63:32];
        REG_CTRL:     bus_rdata <= {26'h0, ctrl};
        REG_STAT:     bus_rdata <= {30'h0, rf_hold, io_ok};
        default:      bus_rdata <= 32'h0;
      endcase
    end
    else
      bus_rdata <= 32'h0;
  end

  // ==========================================================================
  // Assertions
  property p_fixed_bits;
    @(posedge sys_clk) disable iff (!rst_b)
    flags_register[1] && flags_register[63:22] == 42'h0 &&
    !flags_register[15] && !flags_register[5] && !flags_register[3];
  endproperty
  a_fixed_bits: assert property (p_fixed_bits)
    else $error("reserved flag bits wrong");

  property p_legacy;
    @(posedge sys_clk) disable iff (!rst_b)
    legacy_flags_low == flags_register[31:0];
  endproperty
  a_legacy: assert property (p_legacy)
    else $error("legacy view differs");

  property p_step;
    @(posedge sys_clk) disable iff (!rst_b)
    pipe.retire && flags[FL_TRAP] |=> evt.debug_trap && !flags[FL_TRAP];
  endproperty
  a_step: assert property (p_step)
    else $error("step trap missing");

  property p_no_step_on_setter;
    @(posedge sys_clk) disable iff (!rst_b)
    !flags[FL_TRAP] && !pipe.bp_hit |=> !evt.debug_trap;
  endproperty
  a_no_step_on_setter: assert property (p_no_step_on_setter)
    else $error("trap on setting instruction");

  property p_trap_clr;
    @(posedge sys_clk) disable iff (!rst_b)
    pipe.exc_take |=> !flags[FL_TRAP];
  endproperty
  a_trap_clr: assert property (p_trap_clr)
    else $error("trap flag kept on exception");

  property p_int_mask;
    @(posedge sys_clk) disable iff (!rst_b)
    pipe.ext_int |=> evt.int_accept == $past(flags[FL_INT]);
  endproperty
  a_int_mask: assert property (p_int_mask)
    else $error("maskable gating wrong");

  property p_io;
    @(posedge sys_clk) disable iff (!rst_b)
    pipe.io_instr && (current_priv_level > io_priv_level) |=> evt.prot_fault;
  endproperty
  a_io: assert property (p_io)
    else $error("io fault missing");

  property p_nest;
    @(posedge sys_clk) disable iff (!rst_b)
    pipe.gate_nest |=> flags[FL_NEST];
  endproperty
  a_nest: assert property (p_nest)
    else $error("nested task not set");

  property p_rf_defer;
    @(posedge sys_clk) disable iff (!rst_b)
    pipe.retire && pipe.gate_xfer && flags[FL_RESUME] && !pipe.flag_wr
      |=> flags[FL_RESUME];
  endproperty
  a_rf_defer: assert property (p_rf_defer)
    else $error("resume cleared too early");

  property p_bp_stack;
    @(posedge sys_clk) disable iff (!rst_b)
    bp_trap |=> !stack_image[FL_RESUME] && evt.debug_trap;
  endproperty
  a_bp_stack: assert property (p_bp_stack)
    else $error("breakpoint image resume set");

  property p_cr8;
    @(posedge sys_clk) disable iff (!rst_b)
    pipe.cr_access && !ctrl[CT_LONG64] |=> evt.cr_num[3] == 1'b0;
  endproperty
  a_cr8: assert property (p_cr8)
    else $error("extended control reg outside 64-bit");

  c_step: cover property (@(posedge sys_clk) disable iff (!rst_b)
    evt.debug_trap ##1 pipe.retire);
  c_ud: cover property (@(posedge sys_clk) disable iff (!rst_b) evt.bad_opcode);
  c_back: cover property (@(posedge sys_clk) disable iff (!rst_b) evt.task_back);

endmodule : pfc_flags
`default_nettype wire

// File: bench/pfc_flags_test.sv
// Self-checking bench for the flags register block
`timescale 1ns/100ps
`default_nettype none

module pfc_flags_test;
  import pfc_pkg::*;

  // ==========================================================================
  // Signals and scoreboard
  localparam logic [6:0] IMPL = 7'h05;  // Control regs 9 and 11 exist
  typedef struct {int due; int sel; logic [63:0] exp; logic [63:0] msk;} pfc_note_s;
  logic        sys_clk = 1'b0;
  logic        rst_b = 1'b0;
  pfc_pipe_s   pipe = '0;
  logic [3:0]  bus_addr = '0;
  logic [31:0] bus_wdata = '0;
  logic        bus_wr = 1'b0;
  logic        bus_rd = 1'b0;
  logic [31:0] bus_rdata;
  logic [63:0] flags_register;
  logic [63:0] stack_image;
  logic [31:0] legacy_flags_low;
  pfc_evt_s    evt;
  pfc_note_s   q[$];
  int          ncyc = 0;
  int          miscompares = 0;
  int          num_checks = 0;
  string       nm[5] = '{"read data", "flags", "legacy flags", "stack image", "events"};

  pfc_flags #(.CR_IMPL_HI(IMPL)) pfc_flags_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .pipe(pipe), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .flags_register(flags_register), .legacy_flags_low(legacy_flags_low),
    .stack_image(stack_image), .evt(evt));

  // Free-running 200 MHz clock
  initial
  begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ==========================================================================
  // Helpers
  // Event bits in order: trap, prot, opcode, task back, int, nmi, cr valid
  function automatic logic [63:0] ev(input logic [6:0] b);
    pfc_evt_s e;
    e = '0;
    {e.debug_trap, e.prot_fault, e.bad_opcode, e.task_back, e.int_accept,
     e.nmi_accept, e.cr_valid} = b;
    return 64'(e);
  endfunction

  // Flags image a bus write should leave behind
  function automatic logic [63:0] fx(input logic [31:0] d);
    return {42'h0, (d[21:0] & FL_WR_MASK) | FL_ONE_MASK};
  endfunction

  // Result lands at the second falling edge after the drive
  task automatic note(input int s, input logic [63:0] e, input logic [63:0] m = '1);
    q.push_back('{ncyc + 2, s, e, m});
  endtask

  // One cycle of stimulus; every input driven so strobes last one cycle
  task automatic drv(input logic w, input logic r, input logic [3:0] a,
                     input logic [31:0] d, input pfc_pipe_s p);
    bus_wr <= w;
    bus_rd <= r;
    bus_addr <= a;
    bus_wdata <= d;
    pipe <= p;
    @(posedge sys_clk);
  endtask

  task automatic bw(input logic [3:0] a, input logic [31:0] d);
    drv(1'b1, 1'b0, a, d, '0);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    note(0, {32'h0, e});
    drv(1'b0, 1'b1, a, 32'h0, '0);
  endtask

  task automatic pp(input pfc_pipe_s p);
    drv(1'b0, 1'b0, 4'h0, 32'h0, p);
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  task automatic finish_test();
    miscompares += q.size();
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ==========================================================================
  // Monitor: sampled on the falling edge, well clear of the update edge
  initial
  begin
    logic [63:0] got;
    forever
    begin
      @(negedge sys_clk);
      ncyc++;
      while (q.size() != 0 && q[0].due <= ncyc)
      begin
        case (q[0].sel)
          0: got = {32'h0, bus_rdata};
          1: got = flags_register;
          2: got = {32'h0, legacy_flags_low};
          3: got = stack_image;
          default: got = 64'(evt);
        endcase
        num_checks++;
        if ((got & q[0].msk) !== (q[0].exp & q[0].msk) || q[0].due != ncyc)
        begin
          miscompares++;
          $display("wrong value %s: expected %h, seen %h", nm[q[0].sel],
                   q[0].exp & q[0].msk, got & q[0].msk);
        end
        void'(q.pop_front());
      end
    end
  end

  // Watchdog: the sequence needs under two hundred cycles
  initial
  begin
    repeat (4000) @(posedge sys_clk);
    miscompares++;
    finish_test();
  end

  // ==========================================================================
  // Main sequence
  initial
  begin
    logic [31:0] d;
    logic [21:0] a;
    pfc_pipe_s   p;
    logic        ok;
    d = $urandom(32'he30e);
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    note(1, 64'h2);
    note(2, 64'h2);
    note(3, 64'h2);
    note(4, 64'h0);
    pp('0);
    // Random writes; reserved bits and the high word must not move
    for (int i = 0; i < 6; i++)
    begin
      d = $urandom();
      note(1, fx(d));
      bw(REG_FLAGS_LO, d);
      note(2, fx(d));
      bw(REG_FLAGS_HI, $urandom());
      rd(REG_FLAGS_LO, fx(d));
      rd(REG_FLAGS_HI, 32'h0);
      rd(4'h2, 32'h0);
    end
    done("registers");
    // Trap and resume kept clear so retire has no side effects
    for (int i = 0; i < 4; i++)
    begin
      d = $urandom() & 32'hfffefeff;
      a = 22'($urandom());
      bw(REG_FLAGS_LO, d);
      p = '0;
      p.retire = 1'b1;
      p.alu_upd = 1'b1;
      p.alu_flags = a;
      note(1, (fx(d) & ~64'(FL_STAT_MASK)) | 64'(a & FL_STAT_MASK));
      pp(p);
    end
    done("status");
    bw(REG_FLAGS_LO, 32'h2);
    p = '0;
    p.retire = 1'b1;
    p.flag_wr = 1'b1;
    p.flag_wdata = 22'h100;
    p.flag_wmask = 22'h100;
    note(1, 64'h102);
    note(4, ev(7'h0));
    pp(p);
    p = '0;
    p.retire = 1'b1;
    note(1, 64'h2);
    note(4, ev(7'h40));
    pp(p);
    note(4, ev(7'h0));
    pp(p);
    bw(REG_FLAGS_LO, 32'h102);
    p = '0;
    p.exc_take = 1'b1;
    note(1, 64'h0, 64'h100);
    note(3, 64'h10000, 64'h10000);
    pp(p);
    bw(REG_FLAGS_LO, 32'h2);
    p = '0;
    p.str_break = 1'b1;
    note(3, 64'h10002);
    pp(p);
    p = '0;
    p.bp_hit = 1'b1;
    note(4, ev(7'h40), ev(7'h40));
    note(3, 64'h0, 64'h10000);
    pp(p);
    bw(REG_FLAGS_LO, 32'h10002);
    note(4, ev(7'h0), ev(7'h40));
    pp(p);
    done("trap");
    p = '0;
    p.retire = 1'b1;
    note(1, 64'h2);
    pp(p);
    p.return_from_interrupt = 1'b1;
    p.return_from_interrupt_rf = 1'b1;
    note(1, 64'h10000, 64'h10000);
    pp(p);
    p.return_from_interrupt = 1'b0;
    p.return_from_interrupt_rf = 1'b0;
    p.gate_xfer = 1'b1;
    note(1, 64'h10000, 64'h10000);
    pp(p);
    p.gate_xfer = 1'b0;
    note(1, 64'h0, 64'h10000);
    pp(p);
    done("resume");
    bw(REG_CTRL, 32'h1 << CT_LEGACY);
    p = '0;
    p.gate_nest = 1'b1;
    note(1, 64'h4000, 64'h4000);
    pp(p);
    p = '0;
    p.retire = 1'b1;
    p.return_from_interrupt = 1'b1;
    note(4, ev(7'h08), ev(7'h08));
    pp(p);
    bw(REG_CTRL, 32'h1 << CT_LONG64);
    bw(REG_FLAGS_LO, 32'h4002);
    note(4, ev(7'h0), ev(7'h08));
    pp(p);
    done("nesting");
    bw(REG_FLAGS_LO, 32'h202);
    p = '0;
    p.ext_int = 1'b1;
    note(4, ev(7'h04), ev(7'h06));
    pp(p);
    bw(REG_FLAGS_LO, 32'h2);
    note(4, ev(7'h0), ev(7'h06));
    pp(p);
    p = '0;
    p.nmi = 1'b1;
    note(4, ev(7'h02), ev(7'h06));
    pp(p);
    p = '0;
    p.soft_int = 1'b1;
    note(4, ev(7'h02), ev(7'h06));
    pp(p);
    done("interrupts");
    // Every privilege pair, I/O access then an interrupt flag set
    for (int c = 0; c < 4; c++)
      for (int l = 0; l < 4; l++)
      begin
        ok = (c <= l);
        bw(REG_CTRL, 32'(c) << CT_CPL_LO);
        bw(REG_FLAGS_LO, (32'(l) << FL_IO_PRIV_LEVEL_LO) | 32'h2);
        p = '0;
        p.io_instr = 1'b1;
        note(4, ev({1'b0, !ok, 5'h0}));
        pp(p);
        p = '0;
        p.if_op = 1'b1;
        p.if_val = 1'b1;
        note(4, ev({1'b0, !ok, 5'h0}), ev(7'h20));
        note(1, 64'((32'(l) << FL_IO_PRIV_LEVEL_LO) | 32'h2) | (64'(ok) << FL_INT));
        pp(p);
      end
    bw(REG_CTRL, (32'h3 << CT_CPL_LO) | (32'h1 << CT_PVI));
    bw(REG_FLAGS_LO, 32'h2);
    note(4, ev(7'h0), ev(7'h20));
    note(1, 64'h80002);
    pp(p);
    done("privilege");
    // Control register numbers in both modes
    for (int m = 0; m < 2; m++)
    begin
      bw(REG_CTRL, 32'(m) << CT_LONG64);
      rd(REG_CTRL, 32'(m));
      rd(REG_STAT, 32'h1);
      for (int n = 0; n < 8 + 8 * m; n++)
      begin
        ok = (n inside {0, 2, 3, 4}) || (m == 1 && n == 8) || (n > 8 && IMPL[n - 9]);
        p = '0;
        p.cr_access = 1'b1;
        p.reg_extend_prefix_bit = n[3];
        p.operand_select_byte_reg = n[2:0];
        note(4, ev({2'h0, !ok, 3'h0, ok}) | 64'(n), ev(7'h7f) | 64'hf);
        pp(p);
      end
    end
    done("control registers");
    pp('0);
    repeat (3) @(posedge sys_clk);
    finish_test();
  end

endmodule // pfc_flags_test

`default_nettype wire
